// ===== power_mode_pkg.sv
package power_mode_pkg;

	// Register indices; byte address is four times the index
	localparam logic [15:0] PMC_A_INDEX = 16'hfff0;
	localparam logic [15:0] PMC_B_INDEX = 16'hfff1;

	// Reset values, writable masks and fixed-one bits
	localparam logic [7:0] PMC_A_RESET = 8'h07;
	localparam logic [7:0] PMC_B_RESET = 8'hf0;
	localparam logic [7:0] PMC_A_WMASK = 8'hfb;
	localparam logic [7:0] PMC_B_WMASK = 8'h1f;
	localparam logic [7:0] PMC_A_FIXED = 8'h04;
	localparam logic [7:0] PMC_B_FIXED = 8'he0;

	// Field layout of the first control register
	typedef struct packed {
		logic       standby_select;
		logic [2:0] settle_wait;
		logic       low_speed_select;
		logic       fixed_one;
		logic [1:0] medium_divider;
	} ctrl_a_t;

	// Field layout of the second control register
	typedef struct packed {
		logic [2:0] fixed_ones;
		logic       noise_sample_rate;
		logic       direct_transfer_enable;
		logic       medium_speed_select;
		logic [1:0] sub_clock_select;
	} ctrl_b_t;

	// Operating modes, one-hot
	typedef enum logic [8:0] {
		MODE_ACT_HIGH   = 9'h001,
		MODE_ACT_MED    = 9'h002,
		MODE_SUBACT     = 9'h004,
		MODE_SLEEP_HIGH = 9'h008,
		MODE_SLEEP_MED  = 9'h010,
		MODE_SUBSLEEP   = 9'h020,
		MODE_STANDBY    = 9'h040,
		MODE_WATCH      = 9'h080,
		MODE_SETTLE     = 9'h100
	} mode_t;

	// Settle wait codes
	localparam logic [2:0] STS_8K   = 3'h0;
	localparam logic [2:0] STS_16K  = 3'h1;
	localparam logic [2:0] STS_32K  = 3'h2;
	localparam logic [2:0] STS_64K  = 3'h3;
	localparam logic [2:0] STS_128K = 3'h4;
	localparam logic [2:0] STS_EXT  = 3'h5;
	localparam logic [2:0] STS_8    = 3'h6;
	localparam logic [2:0] STS_16   = 3'h7;

	// Short settle waits in states; one state is one clk cycle
	localparam int unsigned WAIT_STATES_EXT = 2;
	localparam int unsigned WAIT_STATES_8   = 8;
	localparam int unsigned WAIT_STATES_16  = 16;
	localparam int unsigned CYCLES_PER_STATE = 1;

	// Prescaler masks: pulse when masked prescaler bits are zero
	localparam logic [6:0] DIV16_MASK  = 7'h0f;
	localparam logic [6:0] DIV32_MASK  = 7'h1f;
	localparam logic [6:0] DIV64_MASK  = 7'h3f;
	localparam logic [6:0] DIV128_MASK = 7'h7f;
	localparam logic [6:0] DIV4_MASK   = 7'h03;

	// Medium divider codes
	localparam logic [1:0] MED_DIV16  = 2'h0;
	localparam logic [1:0] MED_DIV32  = 2'h1;
	localparam logic [1:0] MED_DIV64  = 2'h2;

	// AHB transfer type bit that marks NONSEQ/SEQ
	localparam int unsigned HTRANS_ACTIVE_BIT = 1;

endpackage

// ===== power_mode_control_regs.sv
`timescale 1ns/100ps
// Function
// - Standby clear: sleep/subsleep on sleep instruction
// - Standby set: standby/watch, or watch from subactive
// - Settle code picks wake wait length
// - Hold CPU during settle wait after wake
// - Low speed bit picks clock after watch
// - First register bit 2 reads one
// - Medium divider sets medium-speed clock rate
// - Second register bits 7-5 read one
// - Noise sample rate picks divide by 16/4
// - Direct transfer clear: normal power-down transitions
// - Direct transfer from high-speed active
// - Direct transfer from medium-speed active
// - Direct transfer from subactive to active
// - Wake resumes high or medium by bit
// - Reset loads 07 and f0
// - Standby only when timer watch bit clear
// - Clock restarts, supplied after settle wait
module power_mode_control_regs #(
	parameter int unsigned WAIT_STATES_8K   = 8192,
	parameter int unsigned WAIT_STATES_16K  = 16384,
	parameter int unsigned WAIT_STATES_32K  = 32768,
	parameter int unsigned WAIT_STATES_64K  = 65536,
	parameter int unsigned WAIT_STATES_128K = 131072,
	parameter int unsigned CNT_W            = 18
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	// CPU events and outside control
	input  wire logic                  sleep_exec,
	input  wire logic                  wake_event,
	input  wire logic                  timer_watch_select,
	// Mode and clock controls
	output power_mode_pkg::mode_t      mode_q,
	output logic                       cpu_hold,
	output logic                       osc_run,
	output logic                       cpu_clk_en,
	output logic                       noise_sample_en
);

	// Register state
	power_mode_pkg::ctrl_a_t ctrl_a_q, ctrl_a_d;   // First control register
	power_mode_pkg::ctrl_b_t ctrl_b_q, ctrl_b_d;   // Second control register
	logic                    wr_pend_q, wr_pend_d; // Write data phase pending
	logic                    wr_a_q, wr_a_d;       // Pending write hits first register
	logic                    wr_b_q, wr_b_d;       // Pending write hits second register
	logic [31:0]             rdata_q, rdata_d;     // Registered read data
	// Mode state
	power_mode_pkg::mode_t   mode_d;               // Next mode
	logic [CNT_W-1:0]        settle_q, settle_d;   // Settle wait countdown
	logic [6:0]              presc_q, presc_d;     // Oscillator prescaler
	// Decode helpers
	logic                    addr_phase;           // Valid address phase
	logic                    hit_a, hit_b;         // Address matches
	logic [6:0]              med_mask;             // Medium divider mask
	logic                    med_tick;             // Medium-speed enable tick

	// Settle wait in cycles for a code
	function automatic logic [CNT_W-1:0] settle_cycles(input logic [2:0] code);
		int unsigned states;
		states = power_mode_pkg::WAIT_STATES_16;
		unique case (code)
			power_mode_pkg::STS_8K:   states = WAIT_STATES_8K;
			power_mode_pkg::STS_16K:  states = WAIT_STATES_16K;
			power_mode_pkg::STS_32K:  states = WAIT_STATES_32K;
			power_mode_pkg::STS_64K:  states = WAIT_STATES_64K;
			power_mode_pkg::STS_128K: states = WAIT_STATES_128K;
			power_mode_pkg::STS_EXT:  states = power_mode_pkg::WAIT_STATES_EXT;
			power_mode_pkg::STS_8:    states = power_mode_pkg::WAIT_STATES_8;
			power_mode_pkg::STS_16:   states = power_mode_pkg::WAIT_STATES_16;
		endcase
		return CNT_W'(states * power_mode_pkg::CYCLES_PER_STATE);
	endfunction

	// Zero-wait slave, always OKAY
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign hrdata     = rdata_q;
	assign addr_phase = hsel && hready && htrans[power_mode_pkg::HTRANS_ACTIVE_BIT];
	assign hit_a      = haddr == {14'h0000, power_mode_pkg::PMC_A_INDEX, 2'h0};
	assign hit_b      = haddr == {14'h0000, power_mode_pkg::PMC_B_INDEX, 2'h0};

	// Register file next state; reads see a write landing the same edge
	always_comb begin
		ctrl_a_d  = ctrl_a_q;
		ctrl_b_d  = ctrl_b_q;
		wr_pend_d = addr_phase && hwrite;
		wr_a_d    = hit_a;
		wr_b_d    = hit_b;
		rdata_d   = rdata_q;
		if (wr_pend_q && wr_a_q) begin
			// Reserved bit stays one whatever is written
			ctrl_a_d = (hwdata[7:0] & power_mode_pkg::PMC_A_WMASK) | power_mode_pkg::PMC_A_FIXED;
		end
		if (wr_pend_q && wr_b_q) begin
			ctrl_b_d = (hwdata[7:0] & power_mode_pkg::PMC_B_WMASK) | power_mode_pkg::PMC_B_FIXED;
		end
		if (addr_phase && !hwrite) begin
			// Unmapped addresses read as zero
			if (hit_a) begin
				rdata_d = {24'h000000, ctrl_a_d};
			end else if (hit_b) begin
				rdata_d = {24'h000000, ctrl_b_d};
			end else begin
				rdata_d = 32'h00000000;
			end
		end
	end

	// Register file flops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_a_q  <= power_mode_pkg::PMC_A_RESET;
			ctrl_b_q  <= power_mode_pkg::PMC_B_RESET;
			wr_pend_q <= 1'b0;
			wr_a_q    <= 1'b0;
			wr_b_q    <= 1'b0;
			rdata_q   <= 32'h00000000;
		end else begin
			ctrl_a_q  <= ctrl_a_d;
			ctrl_b_q  <= ctrl_b_d;
			wr_pend_q <= wr_pend_d;
			wr_a_q    <= wr_a_d;
			wr_b_q    <= wr_b_d;
			rdata_q   <= rdata_d;
		end
	end

	// Mode sequencer next state
	always_comb begin
		mode_d   = mode_q;
		settle_d = settle_q;
		unique case (mode_q)
			power_mode_pkg::MODE_ACT_HIGH, power_mode_pkg::MODE_ACT_MED: begin
				if (sleep_exec) begin
					if (ctrl_b_q.direct_transfer_enable && !ctrl_a_q.standby_select
						&& !ctrl_a_q.low_speed_select) begin
						// Direct swap between high and medium speed
						mode_d = ctrl_b_q.medium_speed_select ? power_mode_pkg::MODE_ACT_MED
							: power_mode_pkg::MODE_ACT_HIGH;
					end else if (ctrl_b_q.direct_transfer_enable && ctrl_a_q.standby_select
						&& timer_watch_select && ctrl_a_q.low_speed_select) begin
						mode_d = power_mode_pkg::MODE_SUBACT;
					end else if (!ctrl_a_q.standby_select) begin
						mode_d = ctrl_b_q.medium_speed_select ? power_mode_pkg::MODE_SLEEP_MED
							: power_mode_pkg::MODE_SLEEP_HIGH;
					end else if (!ctrl_a_q.low_speed_select && !timer_watch_select) begin
						mode_d = power_mode_pkg::MODE_STANDBY;
					end else begin
						mode_d = power_mode_pkg::MODE_WATCH;
					end
				end
			end
			power_mode_pkg::MODE_SUBACT: begin
				if (sleep_exec) begin
					if (ctrl_b_q.direct_transfer_enable && ctrl_a_q.standby_select
						&& timer_watch_select && !ctrl_a_q.low_speed_select) begin
						mode_d = ctrl_b_q.medium_speed_select ? power_mode_pkg::MODE_ACT_MED
							: power_mode_pkg::MODE_ACT_HIGH;
					end else if (!ctrl_a_q.standby_select) begin
						mode_d = power_mode_pkg::MODE_SUBSLEEP;
					end else begin
						mode_d = power_mode_pkg::MODE_WATCH;
					end
				end
			end
			power_mode_pkg::MODE_SLEEP_HIGH, power_mode_pkg::MODE_SLEEP_MED: begin
				if (wake_event) begin
					mode_d = ctrl_b_q.medium_speed_select ? power_mode_pkg::MODE_ACT_MED
						: power_mode_pkg::MODE_ACT_HIGH;
				end
			end
			power_mode_pkg::MODE_SUBSLEEP: begin
				if (wake_event) begin
					mode_d = power_mode_pkg::MODE_SUBACT;
				end
			end
			power_mode_pkg::MODE_STANDBY, power_mode_pkg::MODE_WATCH: begin
				if (wake_event) begin
					if (mode_q == power_mode_pkg::MODE_WATCH && ctrl_a_q.low_speed_select) begin
						// Subclock keeps running in watch, so no oscillator wait
						mode_d = power_mode_pkg::MODE_SUBACT;
					end else begin
						mode_d   = power_mode_pkg::MODE_SETTLE;
						settle_d = settle_cycles(ctrl_a_q.settle_wait);
					end
				end
			end
			power_mode_pkg::MODE_SETTLE: begin
				settle_d = settle_q - CNT_W'(1);
				if (settle_q == CNT_W'(1)) begin
					mode_d = ctrl_b_q.medium_speed_select ? power_mode_pkg::MODE_ACT_MED
						: power_mode_pkg::MODE_ACT_HIGH;
				end
			end
			default: begin
				// Corrupt one-hot code recovers to the reset mode
				mode_d = power_mode_pkg::MODE_ACT_HIGH;
			end
		endcase
	end

	// Mode sequencer flops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q   <= power_mode_pkg::MODE_ACT_HIGH;
			settle_q <= '0;
		end else begin
			mode_q   <= mode_d;
			settle_q <= settle_d;
		end
	end

	// Prescaler next value; free running while the oscillator runs
	always_comb begin
		presc_d = osc_run ? presc_q + 7'h01 : presc_q;
	end

	// Prescaler flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			presc_q <= 7'h00;
		end else begin
			presc_q <= presc_d;
		end
	end

	// Medium-speed divider selection
	always_comb begin
		unique case (ctrl_a_q.medium_divider)
			power_mode_pkg::MED_DIV16: med_mask = power_mode_pkg::DIV16_MASK;
			power_mode_pkg::MED_DIV32: med_mask = power_mode_pkg::DIV32_MASK;
			power_mode_pkg::MED_DIV64: med_mask = power_mode_pkg::DIV64_MASK;
			default:                   med_mask = power_mode_pkg::DIV128_MASK;
		endcase
	end

	// Clock and hold controls
	assign med_tick = (presc_q & med_mask) == 7'h00;
	assign osc_run  = !(mode_q inside {power_mode_pkg::MODE_STANDBY, power_mode_pkg::MODE_WATCH});
	// CPU held in every non-active mode and through the settle wait
	assign cpu_hold = !(mode_q inside {power_mode_pkg::MODE_ACT_HIGH,
		power_mode_pkg::MODE_ACT_MED, power_mode_pkg::MODE_SUBACT});
	assign cpu_clk_en = (mode_q inside {power_mode_pkg::MODE_ACT_MED,
		power_mode_pkg::MODE_SLEEP_MED}) ? med_tick
		: (mode_q inside {power_mode_pkg::MODE_ACT_HIGH,
		power_mode_pkg::MODE_SLEEP_HIGH});
	// Noise filter sampling strobe
	assign noise_sample_en = osc_run && ((presc_q & (ctrl_b_q.noise_sample_rate
		? power_mode_pkg::DIV4_MASK : power_mode_pkg::DIV16_MASK)) == 7'h00);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_sleep_entry;
		mode_q == power_mode_pkg::MODE_ACT_HIGH && sleep_exec && !ctrl_a_q.standby_select
			&& !ctrl_b_q.direct_transfer_enable && !ctrl_b_q.medium_speed_select
			|=> mode_q == power_mode_pkg::MODE_SLEEP_HIGH;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

	property p_watch_from_sub;
		mode_q == power_mode_pkg::MODE_SUBACT && sleep_exec && ctrl_a_q.standby_select
			&& !ctrl_b_q.direct_transfer_enable |=> mode_q == power_mode_pkg::MODE_WATCH;
	endproperty
	a_watch_from_sub: assert property (p_watch_from_sub) else $error("watch not entered");

	property p_settle_len;
		mode_q == power_mode_pkg::MODE_STANDBY && wake_event
			&& ctrl_a_q.settle_wait == power_mode_pkg::STS_8
			|=> mode_q == power_mode_pkg::MODE_SETTLE [*8] ##1 mode_q != power_mode_pkg::MODE_SETTLE;
	endproperty
	a_settle_len: assert property (p_settle_len) else $error("settle wait length wrong");

	property p_hold_settle;
		mode_q == power_mode_pkg::MODE_SETTLE |-> cpu_hold && osc_run;
	endproperty
	a_hold_settle: assert property (p_hold_settle) else $error("cpu not held in settle");

	property p_fixed_bits;
		ctrl_a_q.fixed_one && ctrl_b_q.fixed_ones == 3'h7;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("reserved bits not one");

	// Leaving medium speed may bring a full-rate enable; only medium ticks count
	property p_med_spacing;
		mode_q == power_mode_pkg::MODE_ACT_MED && cpu_clk_en && $stable(mode_q)
			|=> (mode_q != power_mode_pkg::MODE_ACT_MED || !cpu_clk_en) [*8];
	endproperty
	a_med_spacing: assert property (p_med_spacing) else $error("medium clock too fast");

	property p_reset_values;
		disable iff (1'b0)
		!rst_n |=> ctrl_a_q == power_mode_pkg::PMC_A_RESET
			&& ctrl_b_q == power_mode_pkg::PMC_B_RESET;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

	property p_standby_twatch;
		mode_q == power_mode_pkg::MODE_ACT_HIGH && sleep_exec && ctrl_a_q.standby_select
			&& timer_watch_select && !ctrl_b_q.direct_transfer_enable
			|=> mode_q == power_mode_pkg::MODE_WATCH;
	endproperty
	a_standby_twatch: assert property (p_standby_twatch) else $error("watch expected");

	property p_mode_stable;
		!sleep_exec && !wake_event && mode_q != power_mode_pkg::MODE_SETTLE
			|=> $stable(mode_q);
	endproperty
	a_mode_stable: assert property (p_mode_stable) else $error("mode changed without event");

	property p_sleep_wake;
		mode_q == power_mode_pkg::MODE_SLEEP_HIGH && wake_event && ctrl_b_q.medium_speed_select
			|=> mode_q == power_mode_pkg::MODE_ACT_MED;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("wrong resume mode");

endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
	// Clock, reset and bus master side
	logic        clk        = 1'b0;
	logic        rst_n      = 1'b0;
	logic        hsel       = 1'b0;
	logic [31:0] haddr      = 32'h0;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [2:0]  hsize      = 3'h2;
	logic [31:0] hwdata     = 32'h0;
	wire         hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	// CPU events and timer watch level
	logic        sleep_exec = 1'b0;
	logic        wake_event = 1'b0;
	logic        tws        = 1'b0;
	// Mode and clock controls seen
	power_mode_pkg::mode_t mode_q;
	logic        cpu_hold;
	logic        osc_run;
	logic        cpu_clk_en;
	logic        noise_sample_en;
	// Bookkeeping
	int          fail_count      = 0;
	int          samples_checked = 0;
	logic [31:0] rd;
	int          n;
	// Short settle lengths, in step with the parameters below
	int          waits[8] = '{20, 24, 28, 32, 36, 2, 8, 16};
	// Byte addresses: index times four
	localparam logic [31:0] ADDR_A = {14'h0, power_mode_pkg::PMC_A_INDEX, 2'h0};
	localparam logic [31:0] ADDR_B = {14'h0, power_mode_pkg::PMC_B_INDEX, 2'h0};

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	// 250 MHz clock
	always #2 clk = ~clk;

	// Long waits shrunk so the whole table runs quickly
	power_mode_control_regs #(
		.WAIT_STATES_8K  (20),
		.WAIT_STATES_16K (24),
		.WAIT_STATES_32K (28),
		.WAIT_STATES_64K (32),
		.WAIT_STATES_128K(36)
	) u_dut (
		.clk               (clk),
		.rst_n             (rst_n),
		.hsel              (hsel),
		.haddr             (haddr),
		.htrans            (htrans),
		.hwrite            (hwrite),
		.hsize             (hsize),
		.hwdata            (hwdata),
		.hready            (hready),
		.hreadyout         (hreadyout),
		.hresp             (hresp),
		.hrdata            (hrdata),
		.sleep_exec        (sleep_exec),
		.wake_event        (wake_event),
		.timer_watch_select(tws),
		.mode_q            (mode_q),
		.cpu_hold          (cpu_hold),
		.osc_run           (osc_run),
		.cpu_clk_en        (cpu_clk_en),
		.noise_sample_en   (noise_sample_en)
	);

	// Compare and count; case inequality so unknowns never match
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask

	// One bus transfer; waits on ready in both phases
	task automatic bus_xfer(input logic [31:0] a, input logic wr, input logic [7:0] d,
			output logic [31:0] r);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		chk("response", 32'h0, {31'h0, hresp});
	endtask

	// Register write
	task automatic bus_write(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] dummy;
		bus_xfer(a, 1'b1, d, dummy);
	endtask

	// One-cycle sleep strobe with the timer watch level set alongside
	task automatic sleep_go(input logic t);
		@(posedge clk);
		sleep_exec <= 1'b1;
		tws        <= t;
		@(posedge clk);
		sleep_exec <= 1'b0;
		#1;
	endtask

	// One-cycle wake strobe
	task automatic wake_go;
		@(posedge clk);
		wake_event <= 1'b1;
		@(posedge clk);
		wake_event <= 1'b0;
		#1;
	endtask

	// Program both registers, strobe sleep, check the new mode
	task automatic step(input logic [7:0] a, input logic [7:0] b, input logic t,
			input logic [8:0] e);
		bus_write(ADDR_A, a);
		bus_write(ADDR_B, b);
		sleep_go(t);
		chk("mode", {23'h0, e}, {23'h0, mode_q});
	endtask

	// Cycles spent in the settle state; bounded against a hang
	task automatic settle_len(output int c);
		c = 0;
		while (mode_q === power_mode_pkg::MODE_SETTLE && c < 2000) begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask

	// Pulses of an enable over a span of cycles
	task automatic count_en(input int cyc, input logic sel, output int c);
		c = 0;
		repeat (cyc) begin
			@(posedge clk);
			#1;
			if ((sel ? noise_sample_en : cpu_clk_en) === 1'b1) c++;
		end
	endtask

	// Verdict in one place
	task automatic report_and_stop;
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		#100000;
		fail_count++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("mode", 32'h1, {23'h0, mode_q});
		bus_xfer(ADDR_A, 1'b0, 8'h0, rd);
		chk("ctrl_a", 32'h07, rd);
		bus_xfer(ADDR_B, 1'b0, 8'h0, rd);
		chk("ctrl_b", 32'hf0, rd);
		// Fixed-one bits ignore writes; writable bits follow
		bus_write(ADDR_A, 8'h00);
		bus_xfer(ADDR_A, 1'b0, 8'h0, rd);
		chk("ctrl_a", 32'h04, rd);
		bus_write(ADDR_B, 8'h00);
		bus_xfer(ADDR_B, 1'b0, 8'h0, rd);
		chk("ctrl_b", 32'he0, rd);
		bus_xfer(32'h0, 1'b0, 8'h0, rd);
		chk("unmapped", 32'h0, rd);
		// Noise sampling: rate bit clear then set
		count_en(64, 1'b1, n);
		chk("noise_pulses", 32'd4, n);
		// Fast noise rate is allowed: the bench clock is far above 16 MHz
		bus_write(ADDR_B, 8'h10);
		count_en(64, 1'b1, n);
		chk("noise_pulses", 32'd16, n);
		// Every medium divider code, set while in high speed
		for (int i = 0; i < 4; i++) begin
			step(8'h04 | 8'(i), 8'h04, 1'b0, 9'h010);
			count_en(256, 1'b0, n);
			chk("cpu_clk_pulses", 32'd256 >> (4 + i), n);
			wake_go();
			chk("mode", 32'h002, {23'h0, mode_q});
			step(8'h04 | 8'(i), 8'h08, 1'b0, 9'h001);
		end
		// Sleep strobe ignored once asleep; wake ignored when active
		step(8'h04, 8'h00, 1'b0, 9'h008);
		sleep_go(1'b0);
		chk("mode", 32'h008, {23'h0, mode_q});
		// Medium bit set while asleep picks the resume speed
		bus_write(ADDR_B, 8'h04);
		wake_go();
		chk("mode", 32'h002, {23'h0, mode_q});
		wake_go();
		chk("mode", 32'h002, {23'h0, mode_q});
		step(8'h04, 8'h08, 1'b0, 9'h001);
		// Standby and every settle code; code 5 treats the bench clock as external
		for (int k = 0; k < 8; k++) begin
			step({1'b1, 3'(k), 4'h7}, 8'h00, 1'b0, 9'h040);
			chk("osc_run", 32'h0, {31'h0, osc_run});
			wake_go();
			chk("cpu_hold", 32'h1, {31'h0, cpu_hold});
			settle_len(n);
			chk("settle_len", waits[k], n);
			chk("mode", 32'h001, {23'h0, mode_q});
		end
		// Direct transfers among the active modes
		step(8'h8c, 8'h08, 1'b1, 9'h004);
		step(8'h84, 8'h0c, 1'b1, 9'h002);
		step(8'h8c, 8'h08, 1'b1, 9'h004);
		step(8'h84, 8'h08, 1'b1, 9'h001);
		step(8'h04, 8'h0c, 1'b0, 9'h002);
		step(8'h04, 8'h08, 1'b0, 9'h001);
		// Watch with low speed set wakes to subactive
		step(8'hec, 8'h00, 1'b1, 9'h080);
		wake_go();
		chk("mode", 32'h004, {23'h0, mode_q});
		step(8'h0c, 8'h00, 1'b0, 9'h020);
		wake_go();
		chk("mode", 32'h004, {23'h0, mode_q});
		// Watch from subactive, low speed clear: settle then system clock
		step(8'h84, 8'h00, 1'b0, 9'h080);
		wake_go();
		settle_len(n);
		chk("settle_len", 32'd20, n);
		chk("mode", 32'h001, {23'h0, mode_q});
		// Timer watch set with low speed clear: watch, not standby
		step(8'h84, 8'h00, 1'b1, 9'h080);
		wake_go();
		settle_len(n);
		chk("settle_len", 32'd20, n);
		chk("mode", 32'h001, {23'h0, mode_q});
		report_and_stop();
	end
endmodule
